// [pkg/acal_regs_pkg.sv]
`default_nettype none
package acal_regs_pkg;

   // ---------------------------------------------------------------
   // register offsets (register port address space)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_AUTOCAL_CONFIG  = 12'h030;
   localparam logic [11:0] ADDR_CALIB_STATUS    = 12'h240;
   localparam logic [11:0] ADDR_CURRENT_PEAK    = 12'h400;
   localparam logic [11:0] ADDR_VOLTAGE_PEAK    = 12'h401;

   // ---------------------------------------------------------------
   // field positions and widths
   // ---------------------------------------------------------------
   localparam int          AUTOCAL_CFG_W        = 7;   // bits 6..0
   localparam int          CALIB_READY_BIT      = 0;
   localparam int          PEAK_SRC_LSB         = 24;  // bits 26..24
   localparam int          PEAK_SRC_W           = 3;
   localparam int          MAG_W                = 24;  // bits 23..0
   localparam int          PEAK_SHIFT           = 5;   // sample / 2^5
   localparam int          SRC_CURRENT_A_BIT    = 0;
   localparam int          SRC_CURRENT_B_BIT    = 1;
   localparam int          SEL_CURRENT_A_BIT    = 0;
   localparam int          SEL_CURRENT_B_BIT    = 1;

   // ---------------------------------------------------------------
   // register port framing
   // ---------------------------------------------------------------
   localparam int          ADDR_W               = 12;
   localparam int          DATA_W               = 32;
   localparam int          CMD_BITS             = 16;
   localparam int          CMD_ADDR_LSB         = 4;   // addr in cmd[15:4]
   localparam int          CMD_READ_BIT         = 3;   // 1 = read
   localparam int          BIT_CNT_W            = 6;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [AUTOCAL_CFG_W-1:0] AUTOCAL_CONFIG_RST = 7'h00;
   localparam logic                     CALIB_READY_RST    = 1'b0;
   localparam logic [MAG_W-1:0]         PEAK_MAG_RST       = 24'h000000;
   localparam logic [PEAK_SRC_W-1:0]    PEAK_SRC_RST       = 3'h0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic voltage_cal_enable;        // bit 6
      logic current_b_cal_enable;      // bit 5
      logic current_a_cal_enable;      // bit 4
      logic current_b_cal_power_mode;  // bit 3, 0 = normal
      logic current_a_cal_power_mode;  // bit 2, 0 = normal
      logic cal_run_bit;               // bit 1
      logic cal_mode_gate;             // bit 0
   } autocal_cfg_t;

   typedef struct packed {
      logic [PEAK_SRC_W-1:0] source;
      logic [MAG_W-1:0]      magnitude;
   } peak_hold_t;

   typedef enum logic [1:0] {
      PORT_IDLE = 2'b00,
      PORT_CMD  = 2'b01,
      PORT_DATA = 2'b10,
      PORT_DONE = 2'b11
   } port_state_t;

endpackage
`default_nettype wire

// [rtl/autocal_control_and_peak_regs.sv]
// Notes on behaviour
// R1: config bit 6 enables voltage channel autocalibration; resets zero, read/write.
// R2: config bit 5 enables current channel B autocalibration; resets zero, read/write.
// R3: config bit 4 enables current channel A autocalibration; resets zero, read/write.
// R4: config bit 3 selects channel B calibration power mode; zero is normal.
// R5: config bit 2 selects channel A calibration power mode; zero is normal.
// R6: run bit 1 starts calibration with bits 6..2; software keeps gate set.
// R7: no calibration runs unless gate bit 0 is set, whatever the run bit.
// R8: while gate is set, all registers except calibration results are inaccessible; here every register but the config register reads zero.
// R9: status bit 0 reads one when calibration system ready; resets zero.
// R10: peak current bits 26..24 report which current channel made the peak.
// R11: source bit 0 set when channel A produced the held peak.
// R12: source bit 1 set when channel B produced the held peak.
// R13: peak current bits 23..0 hold absolute current sample divided by 32.
// R14: peak voltage bits 23..0 hold absolute voltage sample divided by 32.
// R15: peak current monitors only channels chosen by two-bit select field.
// R16: a peak register updates only when a new magnitude exceeds the held one; here a read of it with gate bit 0 clear also zeroes it.
`timescale 1ns/1ps
`default_nettype none
module autocal_control_and_peak_regs #(
   parameter int SAMPLE_W = 32
) (
   input  wire logic                         clk,                   // 200 MHz clock
   input  wire logic                         rst,                   // sync reset, high
   input  wire logic                         sclk,                  // port serial clock
   input  wire logic                         cs_n,                  // port select, low
   input  wire logic                         mosi,                  // port data in
   output logic                              miso,                  // port data out
   output logic                              miso_oe_n,             // miso enable, low
   input  wire logic                         calib_ready_in,        // cal system ready
   input  wire logic [1:0]                   peak_channel_select,   // current peak select
   input  wire logic                         sample_valid,          // new samples strobe
   input  wire logic [SAMPLE_W-1:0]          current_a_sample,      // signed channel A
   input  wire logic [SAMPLE_W-1:0]          current_b_sample,      // signed channel B
   input  wire logic [SAMPLE_W-1:0]          voltage_sample,        // signed voltage
   output acal_regs_pkg::autocal_cfg_t       cal_cfg,               // config to engine
   output logic                              cal_start,             // run start pulse
   output logic                              cal_active,            // run and gate set
   output logic                              access_blocked         // gate locks registers
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [acal_regs_pkg::MAG_W-1:0] scaled_mag(
      input logic [SAMPLE_W-1:0] s
   );
      logic [SAMPLE_W-1:0] a;
      logic [SAMPLE_W-1:0] q;
      a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
      q = a >> acal_regs_pkg::PEAK_SHIFT;
      if (|q[SAMPLE_W-1:acal_regs_pkg::MAG_W])
         return '1;
      return q[acal_regs_pkg::MAG_W-1:0];
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   acal_regs_pkg::port_state_t                 st_ff, nxt_st;
   logic [acal_regs_pkg::BIT_CNT_W-1:0]        cnt_ff, nxt_cnt;
   logic [acal_regs_pkg::DATA_W-1:0]           rx_ff, nxt_rx;
   logic [acal_regs_pkg::DATA_W-1:0]           tx_ff, nxt_tx;
   logic [acal_regs_pkg::ADDR_W-1:0]           addr_ff, nxt_addr;
   logic                                       rd_ff, nxt_rd;
   logic                                       sclk_q_ff;
   logic                                       miso_ff, nxt_miso;
   logic                                       oe_n_ff, nxt_oe_n;
   acal_regs_pkg::autocal_cfg_t                cfg_ff, nxt_cfg;
   logic                                       ready_ff;
   logic                                       start_ff, nxt_start;
   logic                                       active_ff, nxt_active;
   acal_regs_pkg::peak_hold_t                  ipk_ff, nxt_ipk;
   acal_regs_pkg::peak_hold_t                  vpk_ff, nxt_vpk;

   logic                                       rise;
   logic                                       fall;
   logic                                       wr_en;
   logic                                       clr_ipk;
   logic                                       clr_vpk;
   logic [acal_regs_pkg::ADDR_W-1:0]           cmd_addr;
   logic                                       cmd_rd;
   logic [acal_regs_pkg::DATA_W-1:0]           rd_data;

   assign rise     = sclk & ~sclk_q_ff;
   assign fall     = ~sclk & sclk_q_ff;
   assign cmd_addr = rx_ff[acal_regs_pkg::CMD_BITS-1:acal_regs_pkg::CMD_ADDR_LSB];
   assign cmd_rd   = rx_ff[acal_regs_pkg::CMD_READ_BIT];

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_data = '0;
      unique case (cmd_addr)
         acal_regs_pkg::ADDR_AUTOCAL_CONFIG:
            rd_data[acal_regs_pkg::AUTOCAL_CFG_W-1:0] = cfg_ff; // R1 R2 R3 R4 R5
         acal_regs_pkg::ADDR_CALIB_STATUS:
            rd_data[acal_regs_pkg::CALIB_READY_BIT] = ready_ff; // R9
         acal_regs_pkg::ADDR_CURRENT_PEAK:
            rd_data[acal_regs_pkg::PEAK_SRC_LSB+acal_regs_pkg::PEAK_SRC_W-1:0] = ipk_ff; // R10 R13
         acal_regs_pkg::ADDR_VOLTAGE_PEAK:
            rd_data[acal_regs_pkg::MAG_W-1:0] = vpk_ff.magnitude; // R14
         default:
            rd_data = '0;
      endcase
      if (cfg_ff.cal_mode_gate && cmd_addr != acal_regs_pkg::ADDR_AUTOCAL_CONFIG)
         rd_data = '0; // R8
   end

   // ---------------------------------------------------------------
   // serial register port
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_rx   = rx_ff;
      nxt_tx   = tx_ff;
      nxt_addr = addr_ff;
      nxt_rd   = rd_ff;
      nxt_miso = miso_ff;
      nxt_oe_n = 1'b1;
      wr_en    = 1'b0;
      clr_ipk  = 1'b0;
      clr_vpk  = 1'b0;
      if (cs_n)
      begin
         nxt_st  = acal_regs_pkg::PORT_IDLE;
         nxt_cnt = '0;
      end
      else
      begin
         nxt_oe_n = 1'b0;
         unique case (st_ff)
            acal_regs_pkg::PORT_IDLE:
            begin
               nxt_st  = acal_regs_pkg::PORT_CMD;
               nxt_cnt = '0;
               if (rise)
               begin
                  nxt_rx  = {rx_ff[acal_regs_pkg::DATA_W-2:0], mosi};
                  nxt_cnt = 6'h01;
               end
            end
            acal_regs_pkg::PORT_CMD:
            begin
               if (rise)
               begin
                  nxt_rx  = {rx_ff[acal_regs_pkg::DATA_W-2:0], mosi};
                  nxt_cnt = cnt_ff + 6'h01;
               end
               if (cnt_ff == 6'(acal_regs_pkg::CMD_BITS))
               begin
                  nxt_addr = cmd_addr;
                  nxt_rd   = cmd_rd;
                  nxt_tx   = rd_data;
                  nxt_cnt  = '0;
                  nxt_st   = acal_regs_pkg::PORT_DATA;
                  // peak holds restart once captured for a read with gate bit 0 clear
                  if (cmd_rd && !cfg_ff.cal_mode_gate)
                  begin
                     clr_ipk = (cmd_addr == acal_regs_pkg::ADDR_CURRENT_PEAK);
                     clr_vpk = (cmd_addr == acal_regs_pkg::ADDR_VOLTAGE_PEAK);
                  end
               end
            end
            acal_regs_pkg::PORT_DATA:
            begin
               if (fall && rd_ff)
               begin
                  nxt_miso = tx_ff[acal_regs_pkg::DATA_W-1];
                  nxt_tx   = {tx_ff[acal_regs_pkg::DATA_W-2:0], 1'b0};
               end
               if (rise)
               begin
                  nxt_rx  = {rx_ff[acal_regs_pkg::DATA_W-2:0], mosi};
                  nxt_cnt = cnt_ff + 6'h01;
               end
               if (cnt_ff == 6'(acal_regs_pkg::DATA_W))
               begin
                  wr_en  = ~rd_ff;
                  nxt_st = acal_regs_pkg::PORT_DONE;
               end
            end
            acal_regs_pkg::PORT_DONE:
               nxt_st = acal_regs_pkg::PORT_DONE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_ff     <= acal_regs_pkg::PORT_IDLE;
         cnt_ff    <= '0;
         rx_ff     <= '0;
         tx_ff     <= '0;
         addr_ff   <= '0;
         rd_ff     <= 1'b0;
         sclk_q_ff <= 1'b1;
         miso_ff   <= 1'b0;
         oe_n_ff   <= 1'b1;
      end
      else
      begin
         st_ff     <= nxt_st;
         cnt_ff    <= nxt_cnt;
         rx_ff     <= nxt_rx;
         tx_ff     <= nxt_tx;
         addr_ff   <= nxt_addr;
         rd_ff     <= nxt_rd;
         sclk_q_ff <= sclk;
         miso_ff   <= nxt_miso;
         oe_n_ff   <= nxt_oe_n;
      end
   end

   // ---------------------------------------------------------------
   // autocalibration control
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_cfg = cfg_ff;
      if (wr_en && addr_ff == acal_regs_pkg::ADDR_AUTOCAL_CONFIG)
         nxt_cfg = acal_regs_pkg::autocal_cfg_t'(
                      rx_ff[acal_regs_pkg::AUTOCAL_CFG_W-1:0]); // R1 R2 R3 R4 R5
      nxt_active = nxt_cfg.cal_run_bit & nxt_cfg.cal_mode_gate; // R6 R7
      nxt_start  = nxt_active & ~active_ff; // R6
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_ff    <= acal_regs_pkg::autocal_cfg_t'(acal_regs_pkg::AUTOCAL_CONFIG_RST);
         ready_ff  <= acal_regs_pkg::CALIB_READY_RST;
         active_ff <= 1'b0;
         start_ff  <= 1'b0;
      end
      else
      begin
         cfg_ff    <= nxt_cfg;
         ready_ff  <= calib_ready_in; // R9
         active_ff <= nxt_active;
         start_ff  <= nxt_start;
      end
   end

   // ---------------------------------------------------------------
   // peak capture
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [acal_regs_pkg::MAG_W-1:0]      a_mag;
      logic [acal_regs_pkg::MAG_W-1:0]      b_mag;
      logic [acal_regs_pkg::MAG_W-1:0]      v_mag;
      logic [acal_regs_pkg::MAG_W-1:0]      c_mag;
      logic [acal_regs_pkg::PEAK_SRC_W-1:0] c_src;
      logic                                 use_a;
      logic                                 use_b;
      a_mag = scaled_mag(current_a_sample); // R13
      b_mag = scaled_mag(current_b_sample); // R13
      v_mag = scaled_mag(voltage_sample); // R14
      use_a = peak_channel_select[acal_regs_pkg::SEL_CURRENT_A_BIT]; // R15
      use_b = peak_channel_select[acal_regs_pkg::SEL_CURRENT_B_BIT]; // R15
      if (use_a && use_b && a_mag == b_mag)
         use_a = 1'b1;
      else if (use_a && use_b)
      begin
         use_a = a_mag > b_mag;
         use_b = ~use_a;
      end
      c_mag = use_a ? a_mag : (use_b ? b_mag : '0);
      c_src = '0;
      c_src[acal_regs_pkg::SRC_CURRENT_A_BIT] = use_a; // R11
      c_src[acal_regs_pkg::SRC_CURRENT_B_BIT] = use_b; // R12
      nxt_ipk = clr_ipk ? '0 : ipk_ff;
      nxt_vpk = clr_vpk ? '0 : vpk_ff;
      // a sample in the clearing cycle still counts
      if (sample_valid && (use_a || use_b) && c_mag > nxt_ipk.magnitude) // R16
      begin
         nxt_ipk.magnitude = c_mag;
         nxt_ipk.source    = c_src; // R10
      end
      if (sample_valid && v_mag > nxt_vpk.magnitude) // R16
         nxt_vpk.magnitude = v_mag;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ipk_ff <= {acal_regs_pkg::PEAK_SRC_RST, acal_regs_pkg::PEAK_MAG_RST};
         vpk_ff <= {acal_regs_pkg::PEAK_SRC_RST, acal_regs_pkg::PEAK_MAG_RST};
      end
      else
      begin
         ipk_ff <= nxt_ipk;
         vpk_ff <= nxt_vpk;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign miso           = miso_ff;
   assign miso_oe_n      = oe_n_ff;
   assign cal_cfg        = cfg_ff;
   assign cal_start      = start_ff;
   assign cal_active     = active_ff;
   assign access_blocked = cfg_ff.cal_mode_gate; // R8

endmodule
`default_nettype wire

// [sim/acal_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module acal_regs_asserts (
   input wire logic                        clk,             // clock
   input wire logic                        rst,             // sync reset
   input wire logic                        cs_n,            // port select
   input wire acal_regs_pkg::autocal_cfg_t cal_cfg,         // config copy
   input wire logic                        cal_start,       // start pulse
   input wire logic                        cal_active,      // run level
   input wire logic                        access_blocked,  // lock level
   input wire logic                        miso_oe_n        // miso enable
);
   // ---------------------------------------------------------------
   // run control and register lock
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence run_rise;
      $rose(cal_active);
   endsequence
   sequence run_pulse;
      cal_start ##1 !cal_start;
   endsequence
   property start_on_rise;
      run_rise |-> run_pulse;
   endproperty
   cfg_reset_a: assert property (disable iff (1'b0) rst |=> cal_cfg == '0)
      else $error("config not cleared by reset");
   start_rise_a: assert property (start_on_rise)
      else $error("no single start pulse on run rise");
   start_pulse_a: assert property (cal_start |-> cal_active && !$past(cal_active))
      else $error("start pulse without run rise");
   start_gated_a: assert property (cal_start |-> cal_cfg.cal_mode_gate && cal_cfg.cal_run_bit)
      else $error("start pulse without gate and run");
   active_follow_a: assert property (
      cal_active == (cal_cfg.cal_run_bit && cal_cfg.cal_mode_gate))
      else $error("active does not follow run and gate");
   active_off_a: assert property (!cal_cfg.cal_mode_gate |-> !cal_active)
      else $error("active without gate");
   block_gate_a: assert property (access_blocked == cal_cfg.cal_mode_gate)
      else $error("lock differs from gate");
   cfg_hold_a: assert property ($changed(cal_cfg) |-> !$past(cs_n))
      else $error("config changed outside a frame");
   oe_follow_a: assert property (miso_oe_n == $past(cs_n))
      else $error("miso enable does not follow select");
endmodule
bind autocal_control_and_peak_regs acal_regs_asserts u_acal_regs_asserts (
   .clk(clk), .rst(rst), .cs_n(cs_n), .cal_cfg(cal_cfg), .cal_start(cal_start),
   .cal_active(cal_active), .access_blocked(access_blocked), .miso_oe_n(miso_oe_n));
`default_nettype wire

// [sim/autocal_control_and_peak_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module autocal_control_and_peak_regs_bench;
   // ---------------------------------------------------------------
   // stimulus, model and result watcher
   // ---------------------------------------------------------------
   logic clk, rst, sclk, cs_n, mosi, miso, miso_oe_n, calib_ready_in, sample_valid;
   logic [1:0] peak_channel_select;
   logic [31:0] current_a_sample, current_b_sample, voltage_sample;
   acal_regs_pkg::autocal_cfg_t cal_cfg;
   logic cal_start, cal_active, access_blocked;
   logic [31:0] exp_q[$];
   logic [31:0] rd_sh = '0;
   logic [15:0] cmd_sh = '0;
   logic [23:0] ipk = '0, vpk = '0;
   logic [2:0] isrc = '0;
   logic sclk_q = 1'b1, cs_q = 1'b1;
   int nbit = 0, failures = 0, samples_checked = 0, seed = 65, i, k;

   autocal_control_and_peak_regs u_autocal_control_and_peak_regs (.clk(clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
      .calib_ready_in(calib_ready_in), .peak_channel_select(peak_channel_select),
      .sample_valid(sample_valid), .current_a_sample(current_a_sample),
      .current_b_sample(current_b_sample), .voltage_sample(voltage_sample),
      .cal_cfg(cal_cfg), .cal_start(cal_start), .cal_active(cal_active),
      .access_blocked(access_blocked));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_sim;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic frame(input logic [11:0] a, input logic r, input logic [31:0] d);
      logic [47:0] w;
      w = {a, r, 3'h0, d};
      cs_n = 1'b0;
      for (int b = 47; b >= 0; b--)
      begin
         sclk = 1'b0;
         mosi = w[b];
         repeat (2) @(negedge clk);
         sclk = 1'b1;
         repeat (2) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      frame(a, 1'b1, 32'h0);
   endtask

   function automatic logic [23:0] mag(input logic [31:0] s);
      logic [32:0] m;
      m = s[31] ? {1'b0, ~s} + 33'h1 : {1'b0, s};
      m = m >> 5;
      return (m > 33'hffffff) ? 24'hffffff : m[23:0];
   endfunction

   task automatic feed(input logic [31:0] a, input logic [31:0] b, input logic [31:0] v);
      logic [23:0] c;
      logic [2:0] cs;
      c = '0;
      cs = '0;
      if (peak_channel_select[0])
      begin
         c = mag(a);
         cs = 3'h1;
      end
      if (peak_channel_select[1] && (mag(b) > c || !peak_channel_select[0]))
      begin
         c = mag(b);
         cs = 3'h2;
      end
      else if (peak_channel_select == 2'h3 && mag(b) == c)
         cs = 3'h3;
      if (peak_channel_select != 2'h0 && c > ipk)
      begin
         ipk = c;
         isrc = cs;
      end
      if (mag(v) > vpk)
         vpk = mag(v);
      current_a_sample = a;
      current_b_sample = b;
      voltage_sample = v;
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      @(negedge clk);
   endtask

   always @(posedge clk)
   begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (cs_n)
      begin
         if (!cs_q && nbit == 48 && cmd_sh[3])
            chk($sformatf("read %h", cmd_sh[15:4]), exp_q.pop_front(), rd_sh);
         nbit <= 0;
      end
      else if (sclk && !sclk_q && nbit < 48)
      begin
         if (nbit < 16)
            cmd_sh <= {cmd_sh[14:0], mosi};
         else
            rd_sh <= {rd_sh[30:0], miso};
         nbit <= nbit + 1;
      end
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("CHECK FAILED run length expected done seen hang");
      end_sim();
   end

   initial
   begin
      {rst, cs_n, sclk} = 3'b111;
      {mosi, calib_ready_in, sample_valid, peak_channel_select} = '0;
      {current_a_sample, current_b_sample, voltage_sample} = '0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rd(12'h030, 32'h0);
      rd(12'h240, 32'h0);
      rd(12'h400, 32'h0);
      rd(12'h401, 32'h0);
      rd(12'h123, 32'h0);
      frame(12'h030, 1'b0, 32'hffffff7c);
      chk("cal_cfg", 32'h7c, 32'(cal_cfg));
      rd(12'h030, 32'h7c);
      for (i = 2; i < 7; i++)
      begin
         frame(12'h030, 1'b0, 32'h1 << i);
         rd(12'h030, 32'h1 << i);
      end
      calib_ready_in = 1'b1;
      frame(12'h240, 1'b0, 32'h0);
      rd(12'h240, 32'h1);
      for (i = 0; i < 4; i++)
      begin
         peak_channel_select = i[1:0];
         if (i == 3)
            feed(-32'sh1fffffe0, 32'h1fffffe0, 32'h0);
         for (k = 0; k < 6; k++)
            feed($random(seed) >>> (2 * k), $random(seed) >>> (2 * k), $random(seed) >>> k);
         rd(12'h400, {5'h0, isrc, ipk});
         {ipk, isrc} = '0;
         rd(12'h401, {8'h0, vpk});
         vpk = '0;
      end
      peak_channel_select = 2'h1;
      feed(32'h00001000, 32'h0, 32'hffffe000);
      frame(12'h030, 1'b0, 32'h3);
      chk("access_blocked", 32'h1, 32'(access_blocked));
      chk("cal_active", 32'h1, 32'(cal_active));
      rd(12'h400, 32'h0);
      rd(12'h401, 32'h0);
      rd(12'h030, 32'h3);
      frame(12'h030, 1'b0, 32'h0);
      rd(12'h400, {5'h0, isrc, ipk});
      rd(12'h401, {8'h0, vpk});
      frame(12'h030, 1'b0, 32'h2);
      chk("cal_active", 32'h0, 32'(cal_active));
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("cal_cfg", 32'h0, 32'(cal_cfg));
      for (k = 0; k < 20 && exp_q.size() != 0; k++)
         @(negedge clk);
      if (exp_q.size() != 0)
         chk("pending reads", 32'h0, 32'(exp_q.size()));
      end_sim();
   end
endmodule
`default_nettype wire
